// ### core/aefr_recorder.sv
/*
   Error flag and code recorder with query drain and suppress outputs.
   Assumes a command checker on sys_clk reporting one kind per source.
*/
`timescale 1ns/1ps
module aefr_recorder (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [aefr_pkg::NUM_SRC-1:0] err_valid,
   input wire logic [aefr_pkg::NUM_SRC*3-1:0] err_kind,
   input wire logic [aefr_pkg::NUM_SRC-1:0] err_is_system,
   input wire logic error_query_command,
   output logic [aefr_pkg::CODE_W-1:0] query_code,
   output logic query_valid,
   output logic [aefr_pkg::NUM_SRC-1:0] suppress_cmd,
   output logic [aefr_pkg::NUM_SRC-1:0] zero_return,
   output logic [aefr_pkg::NUM_SRC-1:0] block_ptr_write,
   output logic undefined_state,
   output logic [aefr_pkg::NUM_PAIRS-1:0] flags_pending
);
   logic [aefr_pkg::NUM_PAIRS-1:0] flag;
   logic [aefr_pkg::CODE_W-1:0] code [aefr_pkg::NUM_PAIRS];
   logic [aefr_pkg::NUM_SRC-1:0] rec_req;
   logic src_any;
   logic [aefr_pkg::SRC_W-1:0] src_idx;
   logic [aefr_pkg::CODE_W-1:0] next_code;
   logic free_any;
   logic [aefr_pkg::PAIR_W-1:0] free_idx;
   logic full_any;
   logic [aefr_pkg::PAIR_W-1:0] drain_idx;
   logic [aefr_pkg::CODE_W-1:0] next_store_code;
   logic store_hit;
   logic [aefr_pkg::PAIR_W-1:0] store_idx;

   // ------------------------------------------------------------
   // Kind to code mapping.
   // ------------------------------------------------------------
   function automatic logic [aefr_pkg::CODE_W-1:0] kind_code(input logic [2:0] k);
      case (k)
         3'h0: kind_code = aefr_pkg::BAD_SYMBOL_CODE;
         3'h1: kind_code = aefr_pkg::BAD_NUMBER_CODE;
         3'h2: kind_code = aefr_pkg::BAD_STATE_CODE;
         3'h3: kind_code = aefr_pkg::FB_INCOMPLETE_CODE;
         3'h4: kind_code = aefr_pkg::STORAGE_EXHAUSTED_CODE;
         default: kind_code = aefr_pkg::NONE_CODE;
      endcase
   endfunction : kind_code

   function automatic logic kind_known(input logic [2:0] k);
      kind_known = (k <= 3'h4);
   endfunction : kind_known

   // ------------------------------------------------------------
   // Source selection and suppression.
   // ------------------------------------------------------------
   for (genvar s = 0; s < aefr_pkg::NUM_SRC; s++) begin : g_src
      logic [2:0] k;
      logic known;
      assign k = err_kind[s*3 +: 3];
      assign known = kind_known(k);
      // System faults and unknown kinds are neither recorded nor acted on.
      assign rec_req[s] = err_valid[s] & ~err_is_system[s] & known;
      assign suppress_cmd[s] = rec_req[s] & (k != 3'h4);
      assign zero_return[s] = rec_req[s] & (k != 3'h4);
      assign block_ptr_write[s] = rec_req[s] & (k != 3'h4);
   end

   aefr_src_pick u_pick (
      .req(rec_req),
      .any(src_any),
      .idx(src_idx)
   );

   assign next_code = kind_code(err_kind[src_idx*3 +: 3]);

   // ------------------------------------------------------------
   // Pair search: first free pair and first pending pair.
   // ------------------------------------------------------------
   always_comb begin
      free_any = 1'b0;
      free_idx = '0;
      full_any = 1'b0;
      drain_idx = '0;
      for (int p = aefr_pkg::NUM_PAIRS - 1; p >= 0; p--) begin
         if (!flag[p]) begin
            free_any = 1'b1;
            free_idx = aefr_pkg::PAIR_W'(p);
         end
         if (flag[p]) begin
            full_any = 1'b1;
            drain_idx = aefr_pkg::PAIR_W'(p);
         end
      end
   end

   // A pair freed by this query may take a new error in the same cycle.
   assign store_hit = src_any & (free_any | (error_query_command & full_any));
   assign next_store_code = next_code;
   assign store_idx = free_any ? free_idx : drain_idx;

   // ------------------------------------------------------------
   // Flag and code storage.
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flag <= {aefr_pkg::NUM_PAIRS{aefr_pkg::RESET_FLAG}};
         for (int p = 0; p < aefr_pkg::NUM_PAIRS; p++) begin
            code[p] <= aefr_pkg::NONE_CODE;
         end
      end else if (clk_en) begin
         if (error_query_command && full_any) begin
            flag[drain_idx] <= 1'b0;
            code[drain_idx] <= aefr_pkg::NONE_CODE;
         end
         // Store wins over a clear; a set pair is overwritten only when it is drained in the same cycle.
         if (store_hit) begin
            flag[store_idx] <= 1'b1;
            code[store_idx] <= next_store_code;
         end
      end
   end

   // ------------------------------------------------------------
   // Query answer.
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         query_code <= aefr_pkg::NONE_CODE;
         query_valid <= 1'b0;
      end else if (clk_en) begin
         query_valid <= error_query_command;
         if (error_query_command) begin
            query_code <= full_any ? code[drain_idx] : aefr_pkg::NONE_CODE;
         end
      end
   end

   // ------------------------------------------------------------
   // Undefined-results indicator after storage exhaustion.
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         undefined_state <= 1'b0;
      end else if (clk_en) begin
         if (|(rec_req & ~suppress_cmd)) begin
            undefined_state <= 1'b1;
         end
      end
   end

   assign flags_pending = flag;
endmodule : aefr_recorder

// ### core/aefr_pkg.sv
/*
   Constants and types for the error flag recorder.
   Assumes a single synchronous clock domain and plain ports.
*/
package aefr_pkg;
   localparam int CODE_W = 32;
   localparam int NUM_PAIRS = 4;
   localparam int NUM_SRC = 4;
   localparam int SRC_W = 2;
   localparam int PAIR_W = 2;

   // ------------------------------------------------------------
   // Error codes.
   // ------------------------------------------------------------
   localparam logic [CODE_W-1:0] NONE_CODE = 32'h0000_0000;
   localparam logic [CODE_W-1:0] BAD_SYMBOL_CODE = 32'h0000_0500;
   localparam logic [CODE_W-1:0] BAD_NUMBER_CODE = 32'h0000_0501;
   localparam logic [CODE_W-1:0] BAD_STATE_CODE = 32'h0000_0502;
   localparam logic [CODE_W-1:0] STORAGE_EXHAUSTED_CODE = 32'h0000_0505;
   localparam logic [CODE_W-1:0] FB_INCOMPLETE_CODE = 32'h0000_0506;

   // ------------------------------------------------------------
   // Error kinds reported by checking logic.
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      AEFR_KIND_BAD_SYMBOL,
      AEFR_KIND_BAD_NUMBER,
      AEFR_KIND_BAD_STATE,
      AEFR_KIND_FB_INCOMPLETE,
      AEFR_KIND_STORAGE
   } aefr_kind_t;

   localparam logic RESET_FLAG = 1'b0;
endpackage : aefr_pkg

// ### core/aefr_src_pick.sv
/*
   Fixed-priority picker over error sources.
   Assumes requests come from logic on the same clock.
*/
`timescale 1ns/1ps
module aefr_src_pick (
   input wire logic [aefr_pkg::NUM_SRC-1:0] req,
   output logic any,
   output logic [aefr_pkg::SRC_W-1:0] idx
);
   // ------------------------------------------------------------
   // Lowest-numbered request wins.
   // ------------------------------------------------------------
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = aefr_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            idx = aefr_pkg::SRC_W'(i);
         end
      end
   end
endmodule : aefr_src_pick

// ### tb/aefr_cmd_model.sv
/*
   Command checker model that reports errors to the recorder.
   Assumes the bench calls send just after a rising clock edge.
*/
`timescale 1ns/1ps
module aefr_cmd_model (
   output logic [3:0] err_valid,
   output logic [11:0] err_kind,
   output logic [3:0] err_is_system
);
   task send(input logic [3:0] v, input logic [11:0] k, input logic [3:0] s);
      err_valid = v;
      err_kind = k;
      err_is_system = s;
   endtask : send
   initial send(4'h0, 12'h000, 4'h0);
endmodule : aefr_cmd_model

// ### tb/aefr_recorder_properties.sv
/*
   Port checker for the recorder.
   Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
module aefr_recorder_properties (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [3:0] err_valid,
   input wire logic [11:0] err_kind,
   input wire logic [3:0] err_is_system,
   input wire logic error_query_command,
   input wire logic [31:0] query_code,
   input wire logic query_valid,
   input wire logic [3:0] suppress_cmd,
   input wire logic [3:0] zero_return,
   input wire logic [3:0] block_ptr_write,
   input wire logic undefined_state,
   input wire logic [3:0] flags_pending
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   wire q = error_query_command && clk_en;
   wire e0 = err_valid[0] && !err_is_system[0] && clk_en;
   a_query_answer: assert property (q |=> query_valid)
      else $error("query not answered");
   a_no_spurious: assert property (!error_query_command && clk_en |=> !query_valid)
      else $error("answer without query");
   a_empty_none: assert property (q && flags_pending == 0 && err_valid == 0
      |=> query_code == 32'h0) else $error("empty query not none");
   a_first_error: assert property (e0 && err_kind[2:0] <= 3'h4 && flags_pending == 0
      && !q |=> flags_pending == 4'h1) else $error("error not recorded");
   a_flag_sticky: assert property (flags_pending[0] && !q |=> flags_pending[0])
      else $error("flag lost");
   a_last_clears: assert property (q && flags_pending == 4'h1 && err_valid == 0
      |=> flags_pending == 0) else $error("flags not cleared");
   a_suppress_kind: assert property (clk_en |-> suppress_cmd[0] == (err_valid[0]
      && !err_is_system[0] && err_kind[2:0] < 3'h4)) else $error("suppress wrong");
   a_side_effects: assert property (zero_return == suppress_cmd
      && block_ptr_write == suppress_cmd) else $error("side effect mask wrong");
   a_undef_set: assert property (e0 && err_kind[2:0] == 3'h4 |=> undefined_state)
      else $error("storage error not flagged");
   a_undef_sticky: assert property (undefined_state |=> undefined_state)
      else $error("undefined state dropped");
   c_code: cover property (query_valid && query_code != 0);
   c_two_src: cover property (err_valid[0] && err_valid[1]);
   c_full: cover property (flags_pending == 4'hF);
endmodule : aefr_recorder_properties
bind aefr_recorder aefr_recorder_properties u_props (.sys_clk, .srst, .clk_en, .err_valid,
   .err_kind, .err_is_system, .error_query_command, .query_code, .query_valid,
   .suppress_cmd, .zero_return, .block_ptr_write, .undefined_state, .flags_pending);

// ### tb/aefr_recorder_bench.sv
/*
   Self-checking bench for the recorder with a queue model of pending codes.
   Assumes pairs fill and drain lowest index first.
*/
`timescale 1ns/1ps
module aefr_recorder_bench;
   logic sys_clk, srst, clk_en, q, qv, und;
   logic [3:0] ev, sy, sup, zr, bp, fp;
   logic [11:0] ek, rk;
   logic [31:0] qc;
   logic [31:0] exp_q[$];
   logic [31:0] codes [5] = '{aefr_pkg::BAD_SYMBOL_CODE, aefr_pkg::BAD_NUMBER_CODE,
      aefr_pkg::BAD_STATE_CODE, aefr_pkg::FB_INCOMPLETE_CODE, aefr_pkg::STORAGE_EXHAUSTED_CODE};
   int error_cnt = 0;
   int samples_checked = 0;
   aefr_cmd_model m (.err_valid(ev), .err_kind(ek), .err_is_system(sy));
   aefr_recorder dut (.sys_clk, .srst, .clk_en, .err_valid(ev), .err_kind(ek),
      .err_is_system(sy), .error_query_command(q), .query_code(qc), .query_valid(qv),
      .suppress_cmd(sup), .zero_return(zr), .block_ptr_write(bp), .undefined_state(und),
      .flags_pending(fp));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task finish_test;
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task report(input logic [3:0] v, input logic [11:0] k, input logic [3:0] s);
      logic [3:0] x, e;
      logic [2:0] c;
      x = v & ~s;
      for (int i = 3; i >= 0; i--) begin
         e[i] = x[i] && k[3*i+:3] < 3'h4;
         if (x[i]) c = k[3*i+:3];
      end
      if (x != 0 && clk_en && exp_q.size() < 4) exp_q.push_back(codes[c]);
      m.send(v, k, s);
      #1;
      if (clk_en) check("suppress", {20'h0, sup, zr, bp}, {20'h0, e, e, e});
      @(posedge sys_clk);
      #1;
      m.send(4'h0, 12'h000, 4'h0);
      @(posedge sys_clk);
      #1;
   endtask : report
   task query;
      logic [31:0] e;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : aefr_pkg::NONE_CODE;
      q = 1'b1;
      @(posedge sys_clk);
      #1;
      q = 1'b0;
      check("code", qc, e);
      check("valid", {31'h0, qv}, 32'h1);
      @(posedge sys_clk);
      #1;
   endtask : query
   task drain;
      repeat (exp_q.size() + 1) query;
      check("pending", {28'h0, fp}, 32'h0);
   endtask : drain
   initial begin
      q = 1'b0;
      clk_en = 1'b1;
      srst = 1'b1;
      void'($urandom(32'h20105C2E));
      repeat (20) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      check("reset", {27'h0, und, fp}, 32'h0);
      query;
      for (int k = 0; k < 5; k++) begin
         report(4'h1, 12'(k), 4'h0);
         drain;
      end
      check("undefined", {31'h0, und}, 32'h1);
      $display("test kinds done");
      clk_en = 1'b0;
      report(4'h1, 12'h001, 4'h0);
      clk_en = 1'b1;
      query;
      $display("test freeze done");
      repeat (20) begin
         for (int j = 0; j < 4; j++) rk[3*j+:3] = 3'($urandom_range(4));
         repeat (5) report(4'($urandom), rk, 4'($urandom));
         drain;
      end
      $display("test random done");
      finish_test;
   end
   initial begin
      #100000;
      error_cnt++;
      finish_test;
   end
endmodule : aefr_recorder_bench
